/* logic/pps_pkg.sv */
/*
 * Constants, types and register map for the priority shutdown and pair
 * power allocation block of a four-channel slice of a power sourcing controller.
 * Assumes one 200 MHz clock, a synchronous active-high reset, and a host
 * that writes and reads registers through the command port.
 */
// Operation
// - Code at or below setting turns channel off
// - Shutdown acts only with multibit priority enabled
// - Setting 000 highest, 111 lowest priority
// - Setting 101 off except code 111
// - Equal settings shut down together
// - Turn-off like reset, cool-down timer kept
// - Clear event, fault and power-fail bits
// - Clear class, detect, power and enable bits
// - Policing threshold returns to all ones
// - Clear measurement and autoclass results
// - Clear assigned and previous class
// - No memory of earlier shutdown codes
// - Act on code before last pulse ends; a final zero acts only once the pin has fallen
// - Allocation register: two 3-bit fields, reserved bits
// - Field caps class; top bit set reserved
// - Allocation changes after power-on ignored
// - One field serves both channels of pair
// - 4 W allows class 1 only
// - 7 W allows class 1 and 2
package pps_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NCH = 4;
    localparam int FLD_W = 3;
    localparam int CNT_W = 12;

    // ----------------------------------------------------------------
    // Register commands, reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_PRIO_12 = 8'h27;
    localparam logic [7:0] CMD_PRIO_34 = 8'h28;
    localparam logic [7:0] CMD_ALLOC = 8'h29;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] ALLOC_RST = 8'h00;
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 4;
    localparam int RSV_LO_BIT = 3;
    localparam int RSV_HI_BIT = 7;

    // ----------------------------------------------------------------
    // Allocation codes, classes and shutdown codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CAP_15W4 = 3'h0;
    localparam logic [2:0] CAP_4W = 3'h1;
    localparam logic [2:0] CAP_7W = 3'h2;
    localparam logic [2:0] CAP_30W = 3'h3;
    localparam logic [2:0] CLASS_1 = 3'h1;
    localparam logic [2:0] CLASS_2 = 3'h2;
    localparam logic [2:0] CLASS_3 = 3'h3;
    localparam logic [2:0] CLASS_4 = 3'h4;
    localparam logic [2:0] PRIO_LOWEST = 3'h7;
    localparam logic [2:0] PRIO_WIDE = 3'h5;
    localparam logic [1:0] LAST_BIT_IDX = 2'h2;

    // ----------------------------------------------------------------
    // Serial code timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BIT_SAMPLE_NS = 1000;
    localparam int FRAME_GAP_NS = 10000;
    localparam int BIT_SAMPLE_CYC = (BIT_SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FRAME_GAP_CYC = (FRAME_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(BIT_SAMPLE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(FRAME_GAP_CYC - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [NCH-1:0] pps_chan_t;
    typedef logic [NCH-1:0][FLD_W-1:0] pps_field_vec_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } pps_reg_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } pps_reg_rsp_t;

    typedef enum logic [2:0] {
        SD_IDLE = 3'b001,
        SD_PULSE = 3'b010,
        SD_GAP = 3'b100
    } pps_sd_state_t;

endpackage : pps_pkg

/* logic/pps_alloc_check.sv */
/*
 * Per-channel power-on gate: checks the requested class against the pair
 * allocation cap, keeps the power enable of each channel, and drops it on
 * a shutdown or power-off.
 * Assumes requests, class and caps come from logic on the same clock.
 */
`timescale 1ns/1ps
module pps_alloc_check (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire pps_pkg::pps_chan_t power_on_in,
    input wire pps_pkg::pps_chan_t power_off_in,
    input wire pps_pkg::pps_chan_t shutdown_in,
    input wire pps_pkg::pps_field_vec_t class_in,
    input wire pps_pkg::pps_field_vec_t cap_in,
    output pps_pkg::pps_chan_t power_enable_out,
    output pps_pkg::pps_chan_t power_fault_out
);
    import pps_pkg::*;

    typedef struct packed {
        pps_chan_t pe;
        pps_chan_t fault;
    } pps_ac_state_t;

    pps_ac_state_t st_ff;
    pps_ac_state_t nxt_st;
    pps_chan_t allowed;

    // ----------------------------------------------------------------
    // Class against cap, one entry per channel
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_cap
        always_comb begin
            case (cap_in[i])
                CAP_4W: allowed[i] = (class_in[i] == CLASS_1);
                CAP_7W: allowed[i] = (class_in[i] == CLASS_1) || (class_in[i] == CLASS_2);
                CAP_15W4: allowed[i] = (class_in[i] <= CLASS_3);
                CAP_30W: allowed[i] = (class_in[i] <= CLASS_4);
                default: allowed[i] = 1'b0;
            endcase
        end

        cap_4w_a: assert property (
            @(posedge mclk_in) disable iff (reset_in)
            (ce_in && power_on_in[i] && !st_ff.pe[i] && !shutdown_in[i] && !power_off_in[i]
             && cap_in[i] == CAP_4W && class_in[i] != CLASS_1)
            |=> (power_fault_out[i] && !power_enable_out[i]))
            else $error("4 W cap let a non class 1 load power up");

        cap_7w_a: assert property (
            @(posedge mclk_in) disable iff (reset_in)
            (ce_in && power_on_in[i] && !st_ff.pe[i] && !shutdown_in[i] && !power_off_in[i]
             && cap_in[i] == CAP_7W && (class_in[i] == CLASS_1 || class_in[i] == CLASS_2))
            |=> (power_enable_out[i] && !power_fault_out[i]))
            else $error("7 W cap refused a class 1 or 2 load");
    end

    // ----------------------------------------------------------------
    // Next state: shutdown and off win over a power-on request
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.fault = '0;
        for (int i = 0; i < NCH; i++) begin
            if (shutdown_in[i] || power_off_in[i]) begin
                nxt_st.pe[i] = 1'b0;
            end else if (power_on_in[i] && !st_ff.pe[i]) begin
                nxt_st.pe[i] = allowed[i];
                nxt_st.fault[i] = !allowed[i];
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign power_enable_out = st_ff.pe;
    assign power_fault_out = st_ff.fault;

endmodule : pps_alloc_check

/* logic/pps_prio_shutdown.sv */
/*
 * Priority-driven fast shutdown and pair power allocation for four channels.
 * Decodes a 3-bit serial shutdown code from a pin, compares it with each
 * channel priority and pulses a per-channel turn-off; holds the priority and
 * allocation registers reached through the command port.
 * Assumes the pin is asynchronous, the general mask enable and the command
 * port come from logic on mclk_in, and the owners of the status, fault,
 * measurement and policing registers clear them on channel_shutdown_out.
 */
`timescale 1ns/1ps
module pps_prio_shutdown (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic serial_shutdown_input_in,
    input wire logic multibit_priority_enable_in,
    input wire pps_pkg::pps_reg_req_t reg_req_in,
    output pps_pkg::pps_reg_rsp_t reg_rsp_out,
    input wire pps_pkg::pps_chan_t port_power_on_command_in,
    input wire pps_pkg::pps_chan_t port_power_off_in,
    input wire pps_pkg::pps_field_vec_t req_class_in,
    output pps_pkg::pps_chan_t channel_shutdown_out,
    output logic [2:0] shutdown_code_out,
    output pps_pkg::pps_chan_t power_enable_out,
    output pps_pkg::pps_chan_t power_fault_out
);
    import pps_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        pps_sd_state_t sd;
        logic [CNT_W-1:0] cnt;
        logic [1:0] nbits;
        logic [1:0] shreg;
        logic taken;
        logic [7:0] prio12;
        logic [7:0] prio34;
        logic [7:0] alloc;
        pps_chan_t shut;
        logic [2:0] code;
        pps_reg_rsp_t rsp;
    } pps_ps_state_t;

    localparam pps_ps_state_t ST_RST = '{
        s1: 1'b0, s2: 1'b0, s3: 1'b0, sd: SD_IDLE, cnt: '0, nbits: '0,
        shreg: '0, taken: 1'b0, prio12: PRIO_RST, prio34: PRIO_RST,
        alloc: ALLOC_RST, shut: '0, code: '0, rsp: '0
    };

    pps_ps_state_t st_ff;
    pps_ps_state_t nxt_st;

    logic rise;
    logic take;
    logic newbit;
    logic fire;
    logic [2:0] code_now;
    logic [1:0] pair_locked;
    pps_field_vec_t prio_ch;
    pps_field_vec_t cap_ch;
    pps_chan_t hit;
    pps_chan_t lowest_mask;
    pps_chan_t wide_mask;
    pps_chan_t exp_shut;

    // ----------------------------------------------------------------
    // Per-channel views of the registers and the code compare
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam int LSB = (i % 2) * FLD_HI_LSB;
        localparam int PLSB = (i / 2) * FLD_HI_LSB;
        // Channels 1 and 2 live in the first register, 3 and 4 in the second
        assign prio_ch[i] = (i < 2) ? st_ff.prio12[LSB +: FLD_W] : st_ff.prio34[LSB +: FLD_W];
        // Both channels of a pair read the same cap field
        assign cap_ch[i] = st_ff.alloc[PLSB +: FLD_W];
        // Setting 101 is shut down by every code except the top one
        assign wide_mask[i] = (prio_ch[i] == PRIO_WIDE);
        // Higher setting means lower priority; equal settings hit together
        assign hit[i] = (prio_ch[i] >= code_now)
            || (wide_mask[i] && (code_now != PRIO_LOWEST));
        assign lowest_mask[i] = (prio_ch[i] == PRIO_LOWEST);
    end

    // Pair field is frozen while either of its channels is powered
    assign pair_locked[0] = power_enable_out[0] | power_enable_out[1];
    assign pair_locked[1] = power_enable_out[2] | power_enable_out[3];

    assign rise = st_ff.s2 && !st_ff.s3;
    assign code_now = {st_ff.shreg, newbit};
    assign exp_shut = multibit_priority_enable_in ? hit : '0;

    // ----------------------------------------------------------------
    // Serial code receiver: a pulse still high at the sample point is a
    // one, a pulse that ends before it is a zero; most significant first
    // ----------------------------------------------------------------
    always_comb begin
        take = 1'b0;
        newbit = 1'b0;
        fire = 1'b0;
        nxt_st = st_ff;
        nxt_st.s1 = serial_shutdown_input_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.shut = '0;
        nxt_st.rsp = '0;

        case (st_ff.sd)
            SD_IDLE: begin
                if (rise) begin
                    nxt_st.sd = SD_PULSE;
                    nxt_st.cnt = '0;
                    nxt_st.taken = 1'b0;
                end
            end
            SD_PULSE: begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
                if (!st_ff.s2) begin
                    // Short pulse: a zero, taken at its falling edge
                    // Limitation: a final zero acts only once the pin has fallen
                    take = !st_ff.taken;
                    nxt_st.sd = SD_GAP;
                    nxt_st.cnt = '0;
                end else if (!st_ff.taken && st_ff.cnt == SAMPLE_LAST) begin
                    // Long pulse: a one, taken while the pin is still high
                    take = 1'b1;
                    newbit = 1'b1;
                    nxt_st.taken = 1'b1;
                end
            end
            SD_GAP: begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
                if (rise) begin
                    nxt_st.sd = SD_PULSE;
                    nxt_st.cnt = '0;
                    nxt_st.taken = 1'b0;
                end else if (st_ff.cnt == GAP_LAST) begin
                    // A partial code is dropped after a long gap
                    nxt_st.sd = SD_IDLE;
                    nxt_st.nbits = '0;
                end
            end
            default: begin
                nxt_st.sd = SD_IDLE;
                nxt_st.nbits = '0;
            end
        endcase

        // Collect bits; the third one fires the compare at once
        if (take) begin
            if (st_ff.nbits == LAST_BIT_IDX) begin
                fire = 1'b1;
                nxt_st.nbits = '0;
                nxt_st.code = code_now;
                // One-cycle turn-off: owners clear status, faults, class,
                // measurements, and reload policing to all ones; the fault
                // cool-down timer is deliberately not part of this pulse
                nxt_st.shut = exp_shut;
            end else begin
                nxt_st.shreg = {st_ff.shreg[0], newbit};
                nxt_st.nbits = st_ff.nbits + 1'b1;
            end
        end

        // Register writes
        if (reg_req_in.wr) begin
            case (reg_req_in.cmd)
                CMD_PRIO_12: nxt_st.prio12 = reg_req_in.wdata;
                CMD_PRIO_34: nxt_st.prio34 = reg_req_in.wdata;
                CMD_ALLOC: begin
                    // Reserved bits stay writable and read back
                    nxt_st.alloc[RSV_LO_BIT] = reg_req_in.wdata[RSV_LO_BIT];
                    nxt_st.alloc[RSV_HI_BIT] = reg_req_in.wdata[RSV_HI_BIT];
                    if (!pair_locked[0]) begin
                        nxt_st.alloc[FLD_LO_LSB +: FLD_W] =
                            reg_req_in.wdata[FLD_LO_LSB +: FLD_W];
                    end
                    if (!pair_locked[1]) begin
                        nxt_st.alloc[FLD_HI_LSB +: FLD_W] =
                            reg_req_in.wdata[FLD_HI_LSB +: FLD_W];
                    end
                end
                default: nxt_st.rsp.err = 1'b1;
            endcase
            nxt_st.rsp.ack = 1'b1;
        end

        // Register reads; unmapped commands answer zero with an error
        if (reg_req_in.rd) begin
            case (reg_req_in.cmd)
                CMD_PRIO_12: nxt_st.rsp.rdata = st_ff.prio12;
                CMD_PRIO_34: nxt_st.rsp.rdata = st_ff.prio34;
                CMD_ALLOC: nxt_st.rsp.rdata = st_ff.alloc;
                default: nxt_st.rsp.err = 1'b1;
            endcase
            nxt_st.rsp.ack = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register, frozen while the clock enable is low
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st_ff <= ST_RST;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign channel_shutdown_out = st_ff.shut;
    assign shutdown_code_out = st_ff.code;
    assign reg_rsp_out = st_ff.rsp;

    // ----------------------------------------------------------------
    // Power-on gate against the pair caps
    // ----------------------------------------------------------------
    pps_alloc_check u_alloc (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .power_on_in(port_power_on_command_in),
        .power_off_in(port_power_off_in),
        .shutdown_in(st_ff.shut),
        .class_in(req_class_in),
        .cap_in(cap_ch),
        .power_enable_out(power_enable_out),
        .power_fault_out(power_fault_out)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    shut_gate_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in && !multibit_priority_enable_in) |=> (channel_shutdown_out == '0))
        else $error("shutdown issued with multibit priority disabled");

    shut_match_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in && multibit_priority_enable_in) |=> (channel_shutdown_out == $past(hit)))
        else $error("shutdown mask differs from priority compare");

    lowest_prio_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in && multibit_priority_enable_in)
        |=> ((channel_shutdown_out & $past(lowest_mask)) == $past(lowest_mask)))
        else $error("lowest priority channel survived a shutdown code");

    shut_pulse_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && channel_shutdown_out != '0) ##1 ce_in |=> (channel_shutdown_out == '0))
        else $error("turn-off pulse longer than one cycle");

    no_memory_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in) |=> (st_ff.nbits == '0 && shutdown_code_out == $past(code_now)))
        else $error("bit count kept after a code was acted on");

    immediate_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && newbit) |-> (st_ff.s2 && st_ff.sd == SD_PULSE))
        else $error("code with final one acted on after its pulse ended");

    alloc_read_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && reg_req_in.rd && reg_req_in.cmd == CMD_ALLOC)
        |=> (reg_rsp_out.ack && reg_rsp_out.rdata == $past(st_ff.alloc)))
        else $error("allocation read returned a different value");

    alloc_lock_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && pair_locked[0] && reg_req_in.wr && reg_req_in.cmd == CMD_ALLOC)
        |=> $stable(st_ff.alloc[FLD_LO_LSB +: FLD_W]))
        else $error("allocation field changed while its pair is powered");

    // Setting 101 must fall to every code below the top one
    wide_prio_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in && multibit_priority_enable_in && code_now != PRIO_LOWEST)
        |=> ((channel_shutdown_out & $past(wide_mask)) == $past(wide_mask)))
        else $error("setting 101 survived a code below the top one");

    top_code_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (fire && ce_in && multibit_priority_enable_in && code_now == PRIO_LOWEST)
        |=> (channel_shutdown_out == $past(lowest_mask)))
        else $error("top code hit a channel above the lowest setting");

    alloc_write_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && !pair_locked[0] && reg_req_in.wr && reg_req_in.cmd == CMD_ALLOC)
        |=> (st_ff.alloc[FLD_LO_LSB +: FLD_W] == $past(reg_req_in.wdata[FLD_LO_LSB +: FLD_W])))
        else $error("allocation write did not land");

    ce_freeze_a: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        !ce_in |=> $stable(st_ff))
        else $error("state moved while clock enable was low");

endmodule : pps_prio_shutdown

/* tb/pps_host_model.sv */
/*
 * Host side of the shutdown pin: sends one 3-bit code as three high pulses,
 * MSB first, long pulse for 1 and short pulse for 0.
 * Assumes the bench raises start_in for one cycle and waits for busy_out low.
 */
`timescale 1ns/1ps
module pps_host_model (
    input wire logic mclk_in,
    input wire logic start_in,
    input wire logic [2:0] code_in,
    output logic serial_shutdown_input_out,
    output logic busy_out
);
    // ----------------------------------------------------------------
    // Pulse sender
    // ----------------------------------------------------------------
    // Pin idles low; gaps are well above the minimum and below the frame limit
    initial begin
        serial_shutdown_input_out = 1'b0;
        busy_out = 1'b0;
        forever begin
            @(posedge mclk_in);
            if (start_in) begin
                busy_out <= 1'b1;
                for (int b = 2; b >= 0; b--) begin
                    serial_shutdown_input_out <= 1'b1;
                    repeat (code_in[b] ? 300 : 50) @(posedge mclk_in);
                    serial_shutdown_input_out <= 1'b0;
                    repeat (50) @(posedge mclk_in);
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule : pps_host_model

/* tb/port_priority_shutdown_power_alloc_bench.sv */
/*
 * Self-checking bench for the priority shutdown and pair allocation block.
 * Assumes the host model drives the shutdown pin and the bench drives the
 * command port and the power requests.
 */
`timescale 1ns/1ps
module port_priority_shutdown_power_alloc_bench;
    import pps_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic mbp_en = 1'b1;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic [2:0] code = 3'h0;
    logic pin;
    logic busy;
    pps_reg_req_t req = '0;
    pps_reg_rsp_t rsp;
    pps_chan_t pon = '0;
    pps_chan_t poff = '0;
    pps_field_vec_t cls = '0;
    pps_chan_t sd, power_enable, pflt;
    pps_chan_t sd_seen = '0;
    logic [2:0] sd_code;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // Clock, instances, monitors
    // ----------------------------------------------------------------
    // Clock of 5 ns period
    always #2.5 mclk_in = ~mclk_in;

    pps_host_model host (.mclk_in(mclk_in), .start_in(start), .code_in(code),
        .serial_shutdown_input_out(pin), .busy_out(busy));

    pps_prio_shutdown DUT (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce),
        .serial_shutdown_input_in(pin), .multibit_priority_enable_in(mbp_en),
        .reg_req_in(req), .reg_rsp_out(rsp), .port_power_on_command_in(pon),
        .port_power_off_in(poff), .req_class_in(cls), .channel_shutdown_out(sd),
        .shutdown_code_out(sd_code), .power_enable_out(power_enable), .power_fault_out(pflt));

    // Gathers turn-off pulses and cuts a hang short
    always @(posedge mclk_in) begin
        sd_seen <= sd_seen | sd;
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_op(input logic w, input logic [7:0] cmd, input logic [7:0] wd,
                          output pps_reg_rsp_t r);
        @(posedge mclk_in);
        req <= '{wr: w, rd: !w, cmd: cmd, wdata: wd};
        @(posedge mclk_in);
        req <= '0;
        #1 r = rsp;
    endtask : reg_op

    task automatic wr(input logic [7:0] cmd, input logic [7:0] wd);
        pps_reg_rsp_t r;
        reg_op(1'b1, cmd, wd, r);
        chk("wr_rsp", {6'h00, r.ack, r.err}, 8'h02);
    endtask : wr

    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        pps_reg_rsp_t r;
        reg_op(1'b0, cmd, 8'h00, r);
        chk("rd_rsp", {6'h00, r.ack, r.err}, 8'h02);
        chk("rdata", r.rdata, exp);
    endtask : rd_chk

    // Sends one code and compares the channels turned off
    task automatic send(input logic [2:0] c, input pps_chan_t exp);
        int i;
        @(posedge mclk_in);
        code <= c;
        start <= 1'b1;
        @(posedge mclk_in);
        start <= 1'b0;
        #1 sd_seen = '0;
        for (i = 0; i < 3000 && busy; i++) @(posedge mclk_in);
        repeat (20) @(posedge mclk_in);
        #1 chk("shut_mask", {4'h0, sd_seen}, {4'h0, exp});
        chk("shut_code", {5'h00, sd_code}, {5'h00, c});
    endtask : send

    task automatic pwr(input pps_chan_t m, input logic [2:0] c, input pps_chan_t en);
        @(posedge mclk_in);
        pon <= m;
        cls <= {NCH{c}};
        @(posedge mclk_in);
        pon <= '0;
        #1 chk("pwr_en", {4'h0, power_enable}, {4'h0, en});
        chk("pwr_fault", {4'h0, pflt}, {4'h0, m & ~en});
    endtask : pwr

    task automatic off_all;
        @(posedge mclk_in);
        poff <= '1;
        @(posedge mclk_in);
        poff <= '0;
    endtask : off_all

    function automatic logic cap_ok(input logic [2:0] cap, input logic [2:0] c);
        case (cap)
            CAP_15W4: return c <= CLASS_3;
            CAP_4W: return c == CLASS_1;
            CAP_7W: return c <= CLASS_2;
            CAP_30W: return c <= CLASS_4;
            default: return 1'b0;
        endcase
    endfunction : cap_ok

    task automatic end_sim;
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        pps_reg_rsp_t r;
        rd_chk(CMD_PRIO_12, PRIO_RST);
        rd_chk(CMD_ALLOC, ALLOC_RST);
        reg_op(1'b1, 8'h2C, 8'h55, r);
        chk("bad_cmd", {6'h00, r.ack, r.err}, 8'h03);
        wr(CMD_ALLOC, 8'hFF);
        rd_chk(CMD_ALLOC, 8'hFF);
        wr(CMD_ALLOC, 8'h88);
        rd_chk(CMD_ALLOC, 8'h88);
        @(posedge mclk_in);
        ce <= 1'b0;
        reg_op(1'b1, CMD_ALLOC, 8'h11, r);
        chk("frozen_rsp", {6'h00, r.ack, r.err}, 8'h00);
        @(posedge mclk_in);
        ce <= 1'b1;
        rd_chk(CMD_ALLOC, 8'h88);
    endtask : t_regs

    task automatic t_prio;
        wr(CMD_PRIO_12, 8'h20);
        wr(CMD_PRIO_34, 8'h75);
        for (int c = 0; c < 8; c++) begin
            send(3'(c), {3'h7 >= c, c != 7, 3'h2 >= c, 3'h0 >= c});
        end
        wr(CMD_PRIO_12, 8'h33);
        wr(CMD_PRIO_34, 8'h33);
        send(3'h3, 4'hF);
        send(3'h4, 4'h0);
        @(posedge mclk_in);
        mbp_en <= 1'b0;
        send(3'h0, 4'h0);
        @(posedge mclk_in);
        mbp_en <= 1'b1;
    endtask : t_prio

    // Allocation is programmed with all channels off, then power is asked for
    task automatic t_caps;
        logic [2:0] lo, hi;
        for (int cap = 0; cap < 8; cap++) begin
            lo = 3'(cap);
            hi = 3'(cap + 3);
            off_all();
            wr(CMD_ALLOC, {1'b0, hi, 1'b0, lo});
            for (int c = 1; c < 5; c++) begin
                pwr(4'hF, 3'(c), {{2{cap_ok(hi, 3'(c))}}, {2{cap_ok(lo, 3'(c))}}});
                off_all();
            end
        end
    endtask : t_caps

    task automatic t_lock;
        wr(CMD_PRIO_12, 8'h00);
        wr(CMD_PRIO_34, 8'h00);
        wr(CMD_ALLOC, 8'h00);
        pwr(4'h3, CLASS_1, 4'h3);
        wr(CMD_ALLOC, 8'h0B);
        rd_chk(CMD_ALLOC, 8'h08);
        send(3'h0, 4'hF);
        chk("pen_after_shut", {4'h0, power_enable}, 8'h00);
    endtask : t_lock

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_regs();
        t_prio();
        t_caps();
        t_lock();
        end_sim();
    end
endmodule : port_priority_shutdown_power_alloc_bench
